// ==== common/lcsel_defines.svh ====
// Register offsets, field positions and reset values for the cell input stage.
`ifndef LCSEL_DEFINES_SVH
`define LCSEL_DEFINES_SVH

// Byte offsets of the three control registers on the bus.
`define LCSEL_ADDR_POLARITY      4'h0
`define LCSEL_ADDR_SEL_ONE_TWO   4'h4
`define LCSEL_ADDR_SEL_THREE_FOUR 4'h8

// Field positions in the polarity register.
`define LCSEL_POL_CELL_BIT       7
`define LCSEL_POL_GATE_LSB       0
`define LCSEL_POL_GATE_MSB       3

// Field positions in both select registers.
`define LCSEL_SEL_LOW_LSB        0
`define LCSEL_SEL_LOW_MSB        2
`define LCSEL_SEL_HIGH_LSB       4
`define LCSEL_SEL_HIGH_MSB       6

// Reset and read-mask values.
`define LCSEL_CELL_INVERT_RESET  1'h0
`define LCSEL_POL_READ_MASK      8'h8f
`define LCSEL_SEL_READ_MASK      8'h77

// Base input index added to each selector code.
`define LCSEL_BASE_LINE1         4'h0
`define LCSEL_BASE_LINE2         4'h4
`define LCSEL_BASE_LINE3         4'h8
`define LCSEL_BASE_LINE4         4'hc

`endif

// ==== common/lcsel_pkg.sv ====
// Types shared by the cell input stage.
package lcsel_pkg;
  typedef logic [2:0] lcsel_code_type;
  typedef logic [3:0] lcsel_index_type;
  typedef enum logic [1:0] {
    lcsel_idle,
    lcsel_answer
  } lcsel_bus_state_type;
endpackage

// ==== design/lcsel_source_mux.sv ====
// One data-line selector: picks a shared input by a 3-bit code and a base offset.
`timescale 1ns/1ps
`include "lcsel_defines.svh"

module lcsel_source_mux
  import lcsel_pkg::*;
#(
  parameter int INPUTS = 16
)
(
  input  wire logic [INPUTS-1:0] shared_input_bus,
  input  wire lcsel_code_type    code,
  input  wire lcsel_index_type   base,
  output logic                   data_line
);

  lcsel_index_type index;

  // The sum wraps modulo sixteen, which gives line 4 its 12..15 then 0..3 order.
  always_comb
  begin
    index     = lcsel_index_type'(base + {1'b0, code});
    data_line = shared_input_bus[index];
  end

endmodule // lcsel_source_mux

// ==== design/lcsel_top.sv ====
// Input selection and polarity stage of a programmable logic cell, with Avalon-MM slave.
// Operation
// - When the cell invert bit 7 is set the cell result is driven inverted, else unchanged.
// - Polarity bit 3 set inverts gate 4's output before the logic function.
// - Polarity bit 2 set inverts gate 3's output before the logic function.
// - Polarity bit 1 set inverts gate 2's output before the logic function.
// - Polarity bit 0 set inverts gate 1's output before the logic function.
// - Polarity bits 6 to 4 read as zero and ignore writes.
// - Reset clears the cell invert bit; gate polarity and selector fields keep their values.
// - Select-one-two bits 2..0 pick shared input n for data line 1.
// - Select-one-two bits 6..4 pick shared input n plus 4 for data line 2.
// - Select-three-four bits 6..4 pick inputs 12..15 then 0..3 for data line 4.
// - Bits 7 and 3 of both select registers read as zero and ignore writes.
// - Select-three-four bits 2..0 pick shared input n plus 8 for data line 3.
// - Each data line is offered true and inverted, each form gated by its own enable.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "lcsel_defines.svh"

module lcsel_top
  import lcsel_pkg::*;
#(
  parameter int INPUTS = 16,
  parameter int LINES  = 4
)
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [INPUTS-1:0] shared_input_bus,
  input  wire logic [2*LINES*LINES-1:0] gate_term_enable,
  input  wire logic              cell_logic_result,
  output logic [LINES-1:0]       data_lines,
  output logic [LINES-1:0]       gate_outputs,
  output logic                   cell_result_out
);

  lcsel_bus_state_type  bus_state;
  logic                 cell_output_invert;
  logic [3:0]           gate_output_invert;
  lcsel_code_type       data1_source_sel;
  lcsel_code_type       data2_source_sel;
  lcsel_code_type       data3_source_sel;
  lcsel_code_type       data4_source_sel;
  logic                 access;
  logic                 write_hit;
  logic [7:0]           next_read_byte;
  logic [7:0]           polarity_view;
  logic [7:0]           sel_one_two_view;
  logic [7:0]           sel_three_four_view;
  lcsel_code_type       codes [LINES];
  lcsel_index_type      bases [LINES];
  logic [LINES-1:0]     gate_raw;

  // Every access takes one wait cycle, then completes in the answer state.
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & (bus_state != lcsel_answer);
  assign write_hit       = avs_write & (bus_state == lcsel_answer) & avs_byteenable[0];

  // Bus handshake state; the answer state lasts exactly one cycle.
  always_ff @(posedge clock)
  begin
    if (rst)
      bus_state <= lcsel_idle;
    else
    begin
      case (bus_state)
        lcsel_idle:
          if (access)
            bus_state <= lcsel_answer;
        lcsel_answer:
          bus_state <= lcsel_idle;
        default:
          bus_state <= lcsel_idle;
      endcase
    end
  end

  // The cell invert bit is the only field that a reset clears.
  always_ff @(posedge clock)
  begin
    if (rst)
      cell_output_invert <= `LCSEL_CELL_INVERT_RESET;
    else if (write_hit && avs_address == `LCSEL_ADDR_POLARITY)
      cell_output_invert <= avs_writedata[`LCSEL_POL_CELL_BIT];
  end

  // Gate polarity bits survive resets; bits 6..4 are never stored.
  always_ff @(posedge clock)
  begin
    if (write_hit && avs_address == `LCSEL_ADDR_POLARITY)
      gate_output_invert <= avs_writedata[`LCSEL_POL_GATE_MSB:`LCSEL_POL_GATE_LSB];
  end

  // Selector fields survive resets; bits 7 and 3 are never stored.
  always_ff @(posedge clock)
  begin
    if (write_hit && avs_address == `LCSEL_ADDR_SEL_ONE_TWO)
    begin
      data1_source_sel <= avs_writedata[`LCSEL_SEL_LOW_MSB:`LCSEL_SEL_LOW_LSB];
      data2_source_sel <= avs_writedata[`LCSEL_SEL_HIGH_MSB:`LCSEL_SEL_HIGH_LSB];
    end
  end

  always_ff @(posedge clock)
  begin
    if (write_hit && avs_address == `LCSEL_ADDR_SEL_THREE_FOUR)
    begin
      data3_source_sel <= avs_writedata[`LCSEL_SEL_LOW_MSB:`LCSEL_SEL_LOW_LSB];
      data4_source_sel <= avs_writedata[`LCSEL_SEL_HIGH_MSB:`LCSEL_SEL_HIGH_LSB];
    end
  end

  // Read views; unimplemented positions are masked to zero.
  assign polarity_view = {cell_output_invert, 3'h0, gate_output_invert}
                         & `LCSEL_POL_READ_MASK;
  assign sel_one_two_view = {1'b0, data2_source_sel, 1'b0, data1_source_sel}
                            & `LCSEL_SEL_READ_MASK;
  assign sel_three_four_view = {1'b0, data4_source_sel, 1'b0, data3_source_sel}
                               & `LCSEL_SEL_READ_MASK;

  // Unmapped addresses read as zero and writes to them are dropped.
  always_comb
  begin
    case (avs_address)
      `LCSEL_ADDR_POLARITY:       next_read_byte = polarity_view;
      `LCSEL_ADDR_SEL_ONE_TWO:    next_read_byte = sel_one_two_view;
      `LCSEL_ADDR_SEL_THREE_FOUR: next_read_byte = sel_three_four_view;
      default:                    next_read_byte = 8'h00;
    endcase
  end

  // Read data is registered during the wait cycle so it stands at the answer edge.
  always_ff @(posedge clock)
  begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && bus_state == lcsel_idle)
      avs_readdata <= {24'h000000, next_read_byte};
  end

  // Codes and base offsets for the four selectors.
  assign codes[0] = data1_source_sel;
  assign codes[1] = data2_source_sel;
  assign codes[2] = data3_source_sel;
  assign codes[3] = data4_source_sel;
  assign bases[0] = `LCSEL_BASE_LINE1;
  assign bases[1] = `LCSEL_BASE_LINE2;
  assign bases[2] = `LCSEL_BASE_LINE3;
  assign bases[3] = `LCSEL_BASE_LINE4;

  // One selector and one gate per line; the path stays combinational from input to output.
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : gen_line
      logic [2*LINES-1:0] terms;
      lcsel_source_mux #(
        .INPUTS (INPUTS)
      ) u_mux (
        .shared_input_bus (shared_input_bus),
        .code             (codes[g]),
        .base             (bases[g]),
        .data_line        (data_lines[g])
      );
      // Even enable is the inverted form, odd the true form, of each data line.
      for (genvar d = 0; d < LINES; d++)
      begin : gen_term
        assign terms[2*d]   = gate_term_enable[2*LINES*g+2*d] & ~data_lines[d];
        assign terms[2*d+1] = gate_term_enable[2*LINES*g+2*d+1] & data_lines[d];
      end
      assign gate_raw[g]     = |terms;
      assign gate_outputs[g] = gate_raw[g] ^ gate_output_invert[g];
    end
  endgenerate

  // Final inversion of the cell's logic function result.
  assign cell_result_out = cell_logic_result ^ cell_output_invert;

endmodule // lcsel_top

// ==== testbench/lcsel_checker.sv ====
// Port-level assertions for the cell input stage.
`timescale 1ns/1ps
module lcsel_checker #(
  parameter int INPUTS = 16,
  parameter int LINES  = 4
)
(
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic [3:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic [INPUTS-1:0]          shared_input_bus,
  input wire logic [2*LINES*LINES-1:0]   gate_term_enable,
  input wire logic                       cell_logic_result,
  input wire logic [LINES-1:0]           data_lines,
  input wire logic [LINES-1:0]           gate_outputs,
  input wire logic                       cell_result_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Gate terms rebuilt from the visible lines; a read shows the register that ties them.
  logic [7:0] pv;
  logic [3:0] raw;
  logic       rd_done;
  assign pv = {data_lines[3], ~data_lines[3], data_lines[2], ~data_lines[2],
               data_lines[1], ~data_lines[1], data_lines[0], ~data_lines[0]};
  assign rd_done = avs_read && !avs_waitrequest;
  always_comb
    for (int g = 0; g < 4; g++)
      raw[g] = |(gate_term_enable[8*g +: 8] & pv);
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  property p_pol_gap;
    rd_done && avs_address == 4'h0 |-> avs_readdata[6:4] == 3'h0;
  endproperty
  a_pol_gap: assert property (p_pol_gap) else $error("polarity gap bits set");
  property p_sel_gap;
    rd_done && (avs_address == 4'h4 || avs_address == 4'h8) |->
      !avs_readdata[7] && !avs_readdata[3];
  endproperty
  a_sel_gap: assert property (p_sel_gap) else $error("select gap bits set");
  property p_cell_pol;
    rd_done && avs_address == 4'h0 |-> cell_result_out == (cell_logic_result ^ avs_readdata[7]);
  endproperty
  a_cell_pol: assert property (p_cell_pol) else $error("cell output polarity wrong");
  property p_reset_clear;
    $fell(rst) |-> cell_result_out == cell_logic_result;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("cell invert kept");
  property p_lines_12;
    rd_done && avs_address == 4'h4 |->
      data_lines[0] == shared_input_bus[{1'h0, avs_readdata[2:0]}] &&
      data_lines[1] == shared_input_bus[{1'h0, avs_readdata[6:4]} + 4'h4];
  endproperty
  a_lines_12: assert property (p_lines_12) else $error("line 1 or 2 wrong");
  property p_lines_34;
    rd_done && avs_address == 4'h8 |->
      data_lines[2] == shared_input_bus[{1'h1, avs_readdata[2:0]}] &&
      data_lines[3] == shared_input_bus[{1'h0, avs_readdata[6:4]} + 4'hc];
  endproperty
  a_lines_34: assert property (p_lines_34) else $error("line 3 or 4 wrong");
  property p_gate_pol;
    rd_done && avs_address == 4'h0 |-> gate_outputs == (raw ^ avs_readdata[3:0]);
  endproperty
  a_gate_pol: assert property (p_gate_pol) else $error("gate output wrong");
endmodule // lcsel_checker
bind lcsel_top lcsel_checker #(.INPUTS(INPUTS), .LINES(LINES)) chk_u (.clock, .rst,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .shared_input_bus,
  .gate_term_enable, .cell_logic_result, .data_lines, .gate_outputs, .cell_result_out);

// ==== testbench/testbench.sv ====
// Self-checking bench for the cell input stage.
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, cell_logic_result = 1'h0;
  logic        avs_waitrequest, cell_result_out;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, data_lines, gate_outputs;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, gate_term_enable = 32'h0, r;
  logic [15:0] shared_input_bus = 16'h0;
  logic [7:0]  pol, s12, s34;
  logic [31:0] rd_q[$];
  logic [8:0]  out_q[$];
  int          mismatches = 0, compares = 0, cycles = 0, seed = 21839;
  always #2 clock = ~clock;
  lcsel_top dut_u (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .shared_input_bus, .gate_term_enable,
    .cell_logic_result, .data_lines, .gate_outputs, .cell_result_out);
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One Avalon transfer, held until the rising edge at which waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0)
      @(posedge clock);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, {24'h0, d});
    if (a == 4'h0) pol = d & 8'h8f;
    if (a == 4'h4) s12 = d & 8'h77;
    if (a == 4'h8) s34 = d & 8'h77;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back({24'h0, e});
    bus(1'h0, a, 32'h0);
  endtask
  function automatic logic [8:0] expect_out();
    logic [3:0] dl;
    logic [3:0] g;
    dl = {shared_input_bus[{1'h0, s34[6:4]} + 4'hc], shared_input_bus[{1'h1, s34[2:0]}],
          shared_input_bus[{1'h0, s12[6:4]} + 4'h4], shared_input_bus[{1'h0, s12[2:0]}]};
    for (int k = 0; k < 4; k++)
      g[k] = |(gate_term_enable[8*k +: 8] & {dl[3], ~dl[3], dl[2], ~dl[2],
               dl[1], ~dl[1], dl[0], ~dl[0]}) ^ pol[k];
    return {dl, g, cell_logic_result ^ pol[7]};
  endfunction
  // Random inputs land at an edge; the expectation is noted once they have settled.
  task automatic probe();
    @(posedge clock);
    shared_input_bus <= 16'($random(seed));
    gate_term_enable <= $random(seed);
    cell_logic_result <= 1'($random(seed));
    @(negedge clock);
    out_q.push_back(expect_out());
  endtask
  // Scoreboard: the oldest note is compared whenever a result shows.
  always @(posedge clock)
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0 && rd_q.size() != 0)
      check(avs_readdata, rd_q.pop_front(), "read data");
  always @(posedge clock)
    if (out_q.size() != 0)
      check({23'h0, data_lines, gate_outputs, cell_result_out}, {23'h0, out_q.pop_front()}, "outputs");
  // A hung handshake ends the run as a failure rather than silently.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      test_done();
    end
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    wr(4'h0, 8'hff);
    wr(4'h4, 8'hff);
    wr(4'h8, 8'hff);
    rd(4'h0, 8'h8f);
    rd(4'h4, 8'h77);
    rd(4'h8, 8'h77);
    rd(4'hc, 8'h00);
    avs_byteenable <= 4'he;
    bus(1'h1, 4'h0, 32'h0);
    avs_byteenable <= 4'hf;
    rd(4'h0, 8'h8f);
    $display("register test done");
    for (int n = 0; n < 8; n++)
    begin
      r = $random(seed);
      wr(4'h4, {r[7], 3'(n), r[3], 3'(n)});
      wr(4'h8, {r[11], 3'(n), r[15], 3'(7 - n)});
      wr(4'h0, r[23:16]);
      rd(4'h0, pol);
      rd(4'h4, s12);
      rd(4'h8, s34);
      repeat (3) probe();
    end
    $display("selector test done");
    wr(4'h0, 8'h85);
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    pol[7] = 1'h0;
    rd(4'h0, pol);
    rd(4'h8, s34);
    probe();
    @(posedge clock);
    $display("reset test done");
    test_done();
  end
endmodule // testbench
